/* tb/rx_serdes_model.sv */
// Deserializer model: rotated pattern stream and clock-slip answer
`timescale 1ns/1ps
`default_nettype none

module rx_serdes_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Stream setup
  input wire logic [19:0] pat_i,
  input wire logic [4:0] w_i,
  input wire logic [4:0] ph_i,
  input wire logic ones_i,
  input wire logic [3:0] dly_i,
  // Aligner side
  output logic [19:0] rx_data_o,
  input wire logic clkslip_req_i,
  input wire logic [4:0] clkslip_bits_i,
  output logic clkslip_done_o
);
  logic [4:0] ph_r;
  logic [3:0] cnt_r;

  // Word that starts ph bits into a periodic pattern stream
  function automatic logic [19:0] rot(input logic [19:0] p, input logic [4:0] w,
                                      input logic [4:0] ph);
    logic [19:0] r;
    r = 20'h00000;
    for (int i = 0; i < w; i++) begin
      r[i] = p[(i + ph) % w];
    end
    return r;
  endfunction : rot

  // Quiet outputs before the first edge
  initial begin
    rx_data_o = 20'h00000;
    clkslip_done_o = 1'b0;
  end

  // One word per clock; a slip request is answered dly_i cycles after it is first sampled
  always @(posedge clk_sys_i) begin
    clkslip_done_o <= 1'b0;
    rx_data_o <= ones_i ? 20'hfffff : rot(pat_i, w_i, ph_r);
    if (srst_i) begin
      ph_r <= ph_i;
      cnt_r <= 4'h0;
    end else if (clkslip_req_i && !clkslip_done_o) begin
      if (cnt_r == dly_i) begin
        ph_r <= 5'((6'(ph_r) + 6'(clkslip_bits_i)) % w_i);
        clkslip_done_o <= 1'b1;
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule : rx_serdes_model

`default_nettype wire

/* tb/test_rx_word_aligner_sync.sv */
// Self-checking bench for the receive word aligner
`timescale 1ns/1ps
`default_nettype none

module test_rx_word_aligner_sync;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic code_err = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic ones = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [4:0] w = 5'h0a;
  logic [4:0] ph = 5'h00;
  logic ack, req, done, sync, rlv, pdet;
  logic [31:0] rdat, q;
  logic [19:0] rx_in, rx_out;
  logic [4:0] bits;
  int error_cnt = 0;
  int check_count = 0;

  // Design and deserializer model
  rx_word_aligner_sync rx_word_aligner_sync_i (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .rx_data_i(rx_in), .clkslip_req_o(req),
    .clkslip_bits_o(bits), .clkslip_done_i(done), .rx_data_o(rx_out),
    .code_err_i(code_err), .sync_o(sync), .patdet_o(pdet), .rlv_o(rlv), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack));
  rx_serdes_model rx_serdes_model_i (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .pat_i(20'h0017c), .w_i(w), .ph_i(ph),
    .ones_i(ones), .dly_i(4'h5), .rx_data_o(rx_in), .clkslip_req_i(req),
    .clkslip_bits_i(bits), .clkslip_done_o(done));

  // Clock at 125 MHz
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // Classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) begin
      chk(32'h1, 32'h0);
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    chk(q, e);
  endtask : rd

  // Reset with a new stream setup
  task automatic rst(input logic [4:0] wv, input logic [4:0] pv, input logic o);
    @(posedge clk_sys_i);
    w <= wv;
    ph <= pv;
    ones <= o;
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
  endtask : rst

  // Bounded wait for sync or slip request, then compare
  task automatic wsig(input bit on_req, input logic v);
    int n;
    n = 0;
    while ((on_req ? req : sync) !== v && n < 60) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(32'(on_req ? req : sync), 32'(v));
  endtask : wsig

  // Exactly n pattern words between runs of ones
  task automatic burst(input int n);
    @(posedge clk_sys_i);
    ones <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
    ones <= 1'b1;
  endtask : burst

  // n consecutive erroneous groups
  task automatic err(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      code_err <= 1'b1;
    end
    @(posedge clk_sys_i);
    code_err <= 1'b0;
  endtask : err

  function automatic logic [19:0] rev(input logic [19:0] d, input int wd);
    logic [19:0] r;
    r = 20'h00000;
    for (int i = 0; i < wd; i++) begin
      r[i] = d[wd - 1 - i];
    end
    return r;
  endfunction : rev

  task automatic stat_ecnt(input logic [31:0] e);
    wb(8'h10, 1'b0, 32'h0);
    chk(32'(q[13:7]), e);
  endtask : stat_ecnt

  // Test sequence
  initial begin
    rst(5'h0a, 5'h00, 1'b0);
    rd(8'h00, 32'h004);
    rd(8'h04, 32'h03d003);
    rd(8'h08, 32'h0017c);
    wr(8'h20, 32'hffff);
    rd(8'h20, 32'h0);
    rd(8'h0c, 32'h0a0);
    wr(8'h0c, 32'h004);
    rd(8'h0c, 32'h004);
    wr(8'h0c, 32'h3ff);
    rd(8'h0c, 32'h3ff);
    // Threshold 4 is raised to 5 for 10 bits; the pattern's run of 5 passes
    wr(8'h0c, 32'h004);
    repeat (30) @(posedge clk_sys_i);
    chk(32'(rlv), 32'h0);
    ones <= 1'b1;
    repeat (25) @(posedge clk_sys_i);
    chk(32'(rlv), 32'h1);
    ones <= 1'b0;
    wr(8'h10, 32'h2);
    repeat (3) @(posedge clk_sys_i);
    chk(32'(rlv), 32'h0);
    $display("register and run-length test done");
    // Fixed link-training figures override programmed ones
    rst(5'h0a, 5'h00, 1'b1);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h014);
    rd(8'h04, 32'h0);
    burst(3);
    repeat (10) @(posedge clk_sys_i);
    chk(32'(sync), 32'h0);
    burst(4);
    wsig(1'b0, 1'b1);
    err(16);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(sync), 32'h1);
    stat_ecnt(32'd16);
    repeat (20) @(posedge clk_sys_i);
    stat_ecnt(32'd15);
    err(1);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(sync), 32'h1);
    err(1);
    wsig(1'b0, 1'b0);
    repeat (20) @(posedge clk_sys_i);
    chk(32'(sync), 32'h0);
    burst(4);
    wsig(1'b0, 1'b1);
    stat_ecnt(32'd0);
    $display("sync state machine test done");
    // Deterministic latency: stream starts three bits off
    rst(5'h0a, 5'h03, 1'b0);
    wr(8'h00, 32'h005);
    repeat (10) @(posedge clk_sys_i);
    chk(32'(req), 32'h0);
    wr(8'h00, 32'h105);
    wsig(1'b1, 1'b1);
    chk(32'(bits), 32'h7);
    wsig(1'b0, 1'b1);
    repeat (4) @(posedge clk_sys_i);
    chk(32'(rx_out), 32'h0017c);
    chk(32'(pdet), 32'h1);
    wr(8'h00, 32'h125);
    repeat (3) @(posedge clk_sys_i);
    chk(32'(rx_out), 32'h00283);
    wr(8'h00, 32'h145);
    repeat (3) @(posedge clk_sys_i);
    chk(32'(rx_out), 32'(rev(20'h0017c, 10)));
    $display("deterministic latency test done");
    // Double width: swap and reversal at the output
    rst(5'h14, 5'h00, 1'b0);
    wr(8'h00, 32'h00c);
    wsig(1'b0, 1'b1);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(rx_out), 32'h0017c);
    wr(8'h00, 32'h08c);
    repeat (3) @(posedge clk_sys_i);
    chk(32'(rx_out), 32'h5f000);
    wr(8'h00, 32'h04c);
    repeat (3) @(posedge clk_sys_i);
    chk(32'(rx_out), 32'(rev(20'h0017c, 20)));
    $display("double width test done");
    // Bit-slip: swapped symbols on the line, swapped pattern programmed
    rst(5'h14, 5'h0a, 1'b0);
    wr(8'h00, 32'h08e);
    wr(8'h08, 32'h5f000);
    repeat (3) @(posedge clk_sys_i);
    chk(32'(rx_out), 32'h0017c);
    chk(32'(pdet), 32'h1);
    wr(8'h00, 32'h28e);
    wr(8'h00, 32'h08e);
    wb(8'h10, 1'b0, 32'h0);
    chk(32'(q[6:2]), 32'h1);
    wr(8'h00, 32'h0ce);
    wr(8'h08, 32'(rev(20'h5f000, 20)));
    $display("bit-slip test done");
    give_verdict();
  end

  // Hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    give_verdict();
  end
endmodule : test_rx_word_aligner_sync

`default_nettype wire

/* verilog/rx_word_aligner_pkg.sv */
// Constants, register layout and state types of the receive word aligner
package rx_word_aligner_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SYNC = 8'h04;
  localparam logic [7:0] ADDR_PAT = 8'h08;
  localparam logic [7:0] ADDR_RLV = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;

  // Aligner modes
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_DETLAT = 2'h1;
  localparam logic [1:0] MODE_SLIP = 2'h2;

  // Interface widths in bits
  localparam logic [4:0] W8 = 5'h08;
  localparam logic [4:0] W10 = 5'h0a;
  localparam logic [4:0] W16 = 5'h10;
  localparam logic [4:0] W20 = 5'h14;

  // Fixed link-training synchronization figures
  localparam logic [8:0] PCIE_ACQ = 9'h004;
  localparam logic [6:0] PCIE_LOSE = 7'h11;
  localparam logic [8:0] PCIE_GOOD = 9'h010;
  localparam logic [19:0] PCIE_PAT = 20'h0017c;

  // Control register, bit 0 upward: mode, width, pcie, inv, bitrev, swap, arm, slip
  typedef struct packed {
    logic slip;
    logic arm;
    logic swap;
    logic bitrev;
    logic inv;
    logic pcie;
    logic [1:0] width;
    logic [1:0] mode;
  } ctrl_type;

  // Sync parameters, each stored as value minus one
  typedef struct packed {
    logic [7:0] good_m1;
    logic [5:0] lose_m1;
    logic [7:0] acq_m1;
  } sync_cfg_type;

  typedef enum logic [1:0] {
    ST_SEARCH = 2'b00,
    ST_ACQ = 2'b01,
    ST_SYNC = 2'b10,
    ST_CLKSLIP = 2'b11
  } wa_st_type;

  typedef struct packed {
    ctrl_type ctrl;
    sync_cfg_type scfg;
    logic [19:0] pat;
    logic [9:0] thr;
    logic ack;
    logic [31:0] dat;
    wa_st_type st;
    logic sync;
    logic [4:0] bnd;
    logic [19:0] prev;
    logic [8:0] vcnt;
    logic [6:0] ecnt;
    logic [8:0] gcnt;
    logic arm_q;
    logic slip_q;
    logic armed;
    logic slip_req;
    logic [4:0] slip_bits;
    logic [19:0] dout;
    logic patdet;
    logic [9:0] run;
    logic last;
    logic rlv;
  } wa_state_type;

  // Reset values
  localparam ctrl_type CTRL_RST = 10'h004;
  localparam sync_cfg_type SCFG_RST = 22'h03d003;
  localparam logic [19:0] PAT_RST = 20'h0017c;
  localparam logic [9:0] THR_RST = 10'h0a0;

endpackage : rx_word_aligner_pkg

/* verilog/rx_word_aligner_sync.sv */
// Receive word aligner with sync state machine, run-length check and reorder
`timescale 1ns/1ps
`default_nettype none

module rx_word_aligner_sync (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Deserializer side
  input wire logic [19:0] rx_data_i,
  output logic clkslip_req_o,
  output logic [4:0] clkslip_bits_o,
  input wire logic clkslip_done_i,
  // Downstream side
  output logic [19:0] rx_data_o,
  input wire logic code_err_i,
  output logic sync_o,
  output logic patdet_o,
  output logic rlv_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  rx_word_aligner_pkg::wa_state_type s_r;
  rx_word_aligner_pkg::wa_state_type s_nxt;
  logic [4:0] w;
  logic [19:0] m;
  logic [19:0] din;
  logic [39:0] win;
  logic [19:0] pat_e;
  logic cmp_ok;
  logic found;
  logic [4:0] foff;
  logic mb;
  logic viol;
  logic [1:0] mode_e;
  logic [8:0] acq_e;
  logic [6:0] lose_e;
  logic [8:0] good_e;
  logic arm_rise;
  logic slip_rise;

  // Interface width from the width code
  function automatic logic [4:0] width_bits(input logic pcie, input logic [1:0] code);
    logic [4:0] r;
    case (code)
      2'h0: r = rx_word_aligner_pkg::W8;
      2'h1: r = rx_word_aligner_pkg::W10;
      2'h2: r = rx_word_aligner_pkg::W16;
      default: r = rx_word_aligner_pkg::W20;
    endcase
    if (pcie) r = rx_word_aligner_pkg::W10;
    return r;
  endfunction : width_bits

  // Mask for the active low bits of a word
  function automatic logic [19:0] wmask(input logic [4:0] wb);
    return 20'((21'h000001 << wb) - 21'h000001);
  endfunction : wmask

  // Word that starts k bits into the two-word window
  function automatic logic [19:0] cand(input logic [39:0] wn, input logic [4:0] k,
                                       input logic [19:0] mk);
    return 20'(wn >> k) & mk;
  endfunction : cand

  // Pattern, or optionally its complement, at offset k
  function automatic logic hit(input logic [39:0] wn, input logic [4:0] k,
                               input logic [19:0] mk, input logic [19:0] p,
                               input logic cmp);
    logic [19:0] c;
    c = cand(wn, k, mk);
    return (c == (p & mk)) || (cmp && (c == (~p & mk)));
  endfunction : hit

  // Run-length limit clamped to the range of the width
  function automatic logic [9:0] rlv_limit(input logic [4:0] wb, input logic [9:0] t);
    logic [9:0] lo;
    logic [9:0] hi;
    lo = 10'(wb >> 1);
    hi = (wb >= rx_word_aligner_pkg::W16) ? 10'(wb) << 5 : 10'(wb) << 4;
    if (t < lo) return lo;
    if (t > hi) return hi;
    return t;
  endfunction : rlv_limit

  // Byte-lane merge of a bus write
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] sel);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = sel[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // Effective configuration; PCIe overrides mode, pattern and figures
  always_comb begin
    mode_e = s_r.ctrl.pcie ? rx_word_aligner_pkg::MODE_AUTO : s_r.ctrl.mode;
    w = width_bits(s_r.ctrl.pcie, s_r.ctrl.width);
    m = wmask(w);
    pat_e = s_r.ctrl.pcie ? rx_word_aligner_pkg::PCIE_PAT : s_r.pat;
    acq_e = s_r.ctrl.pcie ? rx_word_aligner_pkg::PCIE_ACQ : 9'(s_r.scfg.acq_m1) + 9'h001;
    lose_e = s_r.ctrl.pcie ? rx_word_aligner_pkg::PCIE_LOSE : 7'(s_r.scfg.lose_m1) + 7'h01;
    good_e = s_r.ctrl.pcie ? rx_word_aligner_pkg::PCIE_GOOD : 9'(s_r.scfg.good_m1) + 9'h001;
    cmp_ok = (w == rx_word_aligner_pkg::W10) || (w == rx_word_aligner_pkg::W20);
    arm_rise = s_r.ctrl.arm && !s_r.arm_q;
    slip_rise = s_r.ctrl.slip && !s_r.slip_q;
  end

  // Input inversion, window and boundary search
  always_comb begin
    din = (s_r.ctrl.inv ? ~rx_data_i : rx_data_i) & m;
    win = (40'(din) << w) | 40'(s_r.prev & m);
    found = 1'b0;
    foff = 5'h00;
    for (int k = 0; k < 20; k++) begin
      if (!found && (5'(k) < w) && hit(win, 5'(k), m, pat_e, cmp_ok)) begin
        found = 1'b1;
        foff = 5'(k);
      end
    end
    mb = hit(win, s_r.bnd, m, pat_e, cmp_ok);
  end

  // Next state
  always_comb begin
    logic [19:0] al;
    logic [19:0] rv;
    logic [9:0] run;
    logic lastb;
    logic [9:0] lim;
    logic [4:0] h;
    al = '0;
    rv = '0;
    run = s_r.run;
    lastb = s_r.last;
    lim = rlv_limit(w, s_r.thr);
    h = w >> 1;
    viol = 1'b0;
    s_nxt = s_r;
    s_nxt.prev = din;
    s_nxt.arm_q = s_r.ctrl.arm;
    s_nxt.slip_q = s_r.ctrl.slip;

    // Run-length check across word boundaries
    for (int i = 0; i < 20; i++) begin
      if (5'(i) < w) begin
        if (din[i] == lastb) begin
          run = (run == 10'h3ff) ? run : run + 10'h001;
        end else begin
          run = 10'h001;
          lastb = din[i];
        end
        if (run > lim) viol = 1'b1;
      end
    end
    s_nxt.run = run;
    s_nxt.last = lastb;
    if (viol) s_nxt.rlv = 1'b1;

    // Aligned word, bit reversal, symbol swap
    al = cand(win, s_r.bnd, m);
    for (int i = 0; i < 20; i++) begin
      rv[i] = al[19-i];
    end
    if (s_r.ctrl.bitrev) al = 20'(rv >> (5'h14 - w));
    if (s_r.ctrl.swap && (w >= rx_word_aligner_pkg::W16)) begin
      al = ((al >> h) | (al << h)) & m;
    end
    s_nxt.dout = al;
    s_nxt.patdet = mb;

    // Synchronization state machine
    case (mode_e)
      rx_word_aligner_pkg::MODE_AUTO: begin
        case (s_r.st)
          rx_word_aligner_pkg::ST_SEARCH: begin
            if (found) begin
              s_nxt.bnd = foff;
              s_nxt.vcnt = 9'h001;
              s_nxt.st = rx_word_aligner_pkg::ST_ACQ;
              if (acq_e == 9'h001) begin
                s_nxt.st = rx_word_aligner_pkg::ST_SYNC;
                s_nxt.sync = 1'b1;
                s_nxt.ecnt = '0;
                s_nxt.gcnt = '0;
              end
            end
          end
          rx_word_aligner_pkg::ST_ACQ: begin
            if (code_err_i) begin
              s_nxt.st = rx_word_aligner_pkg::ST_SEARCH;
              s_nxt.vcnt = '0;
            end else if (mb) begin
              s_nxt.vcnt = s_r.vcnt + 9'h001;
              if (s_r.vcnt + 9'h001 >= acq_e) begin
                s_nxt.st = rx_word_aligner_pkg::ST_SYNC;
                s_nxt.sync = 1'b1;
                s_nxt.ecnt = '0;
                s_nxt.gcnt = '0;
              end
            end
          end
          rx_word_aligner_pkg::ST_SYNC: begin
            if (code_err_i) begin
              s_nxt.gcnt = '0;
              s_nxt.ecnt = s_r.ecnt + 7'h01;
              if (s_r.ecnt + 7'h01 >= lose_e) begin
                s_nxt.st = rx_word_aligner_pkg::ST_SEARCH;
                s_nxt.sync = 1'b0;
                s_nxt.ecnt = '0;
                s_nxt.vcnt = '0;
              end
            end else if (s_r.gcnt + 9'h001 >= good_e) begin
              s_nxt.gcnt = '0;
              if (s_r.ecnt != 7'h00) s_nxt.ecnt = s_r.ecnt - 7'h01;
            end else begin
              s_nxt.gcnt = s_r.gcnt + 9'h001;
            end
          end
          default: begin
            s_nxt.st = rx_word_aligner_pkg::ST_SEARCH;
            s_nxt.sync = 1'b0;
          end
        endcase
      end
      rx_word_aligner_pkg::MODE_DETLAT: begin
        if (s_r.st == rx_word_aligner_pkg::ST_CLKSLIP) begin
          if (clkslip_done_i) begin
            s_nxt.slip_req = 1'b0;
            s_nxt.bnd = '0;
            s_nxt.sync = 1'b1;
            s_nxt.armed = 1'b0;
            s_nxt.st = rx_word_aligner_pkg::ST_SYNC;
          end
        end else if (arm_rise) begin
          s_nxt.armed = 1'b1;
          s_nxt.sync = 1'b0;
          s_nxt.st = rx_word_aligner_pkg::ST_SEARCH;
        end else if (s_r.armed && found && (s_r.st == rx_word_aligner_pkg::ST_SEARCH)) begin
          s_nxt.slip_req = 1'b1;
          s_nxt.slip_bits = foff;
          s_nxt.st = rx_word_aligner_pkg::ST_CLKSLIP;
        end
      end
      default: begin
        if (slip_rise) begin
          s_nxt.bnd = (s_r.bnd + 5'h01 >= w) ? 5'h00 : s_r.bnd + 5'h01;
        end
      end
    endcase

    // Wishbone slave: ack one cycle after request, write on acked edge
    s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
    case (wb_adr_i)
      rx_word_aligner_pkg::ADDR_CTRL: s_nxt.dat = 32'(s_r.ctrl);
      rx_word_aligner_pkg::ADDR_SYNC: s_nxt.dat = 32'(s_r.scfg);
      rx_word_aligner_pkg::ADDR_PAT: s_nxt.dat = 32'(s_r.pat);
      rx_word_aligner_pkg::ADDR_RLV: s_nxt.dat = 32'(s_r.thr);
      rx_word_aligner_pkg::ADDR_STAT: s_nxt.dat = {16'h0000, s_r.st, s_r.ecnt, s_r.bnd,
                                                   s_r.rlv, s_r.sync};
      default: s_nxt.dat = 32'h00000000;
    endcase
    if (wb_cyc_i && wb_stb_i && wb_we_i && s_r.ack) begin
      case (wb_adr_i)
        rx_word_aligner_pkg::ADDR_CTRL: s_nxt.ctrl = 10'(merge(32'(s_r.ctrl), wb_dat_i, wb_sel_i));
        rx_word_aligner_pkg::ADDR_SYNC: s_nxt.scfg = 22'(merge(32'(s_r.scfg), wb_dat_i, wb_sel_i));
        rx_word_aligner_pkg::ADDR_PAT: s_nxt.pat = 20'(merge(32'(s_r.pat), wb_dat_i, wb_sel_i));
        rx_word_aligner_pkg::ADDR_RLV: s_nxt.thr = 10'(merge(32'(s_r.thr), wb_dat_i, wb_sel_i));
        rx_word_aligner_pkg::ADDR_STAT: begin
          if (wb_sel_i[0] && wb_dat_i[1] && !viol) s_nxt.rlv = 1'b0;
        end
        default: s_nxt.rlv = s_nxt.rlv;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_r <= '{ctrl: rx_word_aligner_pkg::CTRL_RST, scfg: rx_word_aligner_pkg::SCFG_RST,
               pat: rx_word_aligner_pkg::PAT_RST, thr: rx_word_aligner_pkg::THR_RST,
               st: rx_word_aligner_pkg::ST_SEARCH, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign rx_data_o = s_r.dout;
  assign sync_o = s_r.sync;
  assign patdet_o = s_r.patdet;
  assign rlv_o = s_r.rlv;
  assign clkslip_req_o = s_r.slip_req;
  assign clkslip_bits_o = s_r.slip_bits;
  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  chk_pcie_acq_count: assert property ($rose(s_r.sync) && s_r.ctrl.pcie |->
    $past(s_r.vcnt) == 9'h003) else $error("pcie sync gained at wrong count");
  chk_pcie_lose_count: assert property ($fell(s_r.sync) && s_r.ctrl.pcie |->
    $past(s_r.ecnt) == 7'h10) else $error("pcie sync lost at wrong count");
  chk_pcie_err_dec: assert property (s_r.ctrl.pcie && s_r.st == rx_word_aligner_pkg::ST_SYNC
    && !code_err_i && s_r.gcnt == 9'h00f && s_r.ecnt != 7'h00
    |=> s_r.ecnt == $past(s_r.ecnt) - 7'h01)
    else $error("error count not reduced after good run");
  chk_err_floor: assert property (mode_e == rx_word_aligner_pkg::MODE_AUTO && !code_err_i
    && s_r.ecnt == 7'h00 |=> s_r.ecnt == 7'h00) else $error("error count below zero");
  chk_sync_hold: assert property (mode_e == rx_word_aligner_pkg::MODE_AUTO && sync_o
    && !code_err_i |=> sync_o) else $error("sync dropped without error");
  chk_rlv_flag: assert property (viol |=> rlv_o) else $error("run-length violation missed");
  chk_slip_cmd: assert property (mode_e == rx_word_aligner_pkg::MODE_DETLAT && s_r.armed
    && found && s_r.st == rx_word_aligner_pkg::ST_SEARCH && !arm_rise
    |=> clkslip_req_o && clkslip_bits_o == $past(foff)) else $error("clock-slip not requested");
  chk_slip_done: assert property (clkslip_req_o && clkslip_done_i
    && mode_e == rx_word_aligner_pkg::MODE_DETLAT |=> sync_o && !clkslip_req_o)
    else $error("sync not raised after clock-slip");
  chk_bitslip_step: assert property (mode_e == rx_word_aligner_pkg::MODE_SLIP && slip_rise
    && s_r.bnd == 5'h00 && w > 5'h01 |=> s_r.bnd == 5'h01) else $error("bit slip not applied");
  chk_wb_ack: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");

  cov_sync_gain: cover property ($rose(sync_o));
  cov_sync_loss: cover property ($fell(sync_o));
  cov_detlat: cover property (clkslip_req_o ##[1:20] sync_o);
  cov_rlv: cover property ($rose(rlv_o));

endmodule : rx_word_aligner_sync

`default_nettype wire
